// ===== sopd_defines.svh
`ifndef SOPD_DEFINES_SVH
`define SOPD_DEFINES_SVH

// byte addresses of the three configuration bytes, most significant first
`define SOPD_ADDR_HI 8'h86
`define SOPD_ADDR_MID 8'h87
`define SOPD_ADDR_LO 8'h88

// register reset value: clock mode, divide by 64
`define SOPD_CFG_RESET 24'h000040

// field positions
`define SOPD_MODE_HI 23
`define SOPD_MODE_LO 20
`define SOPD_TYPE_BIT 19
`define SOPD_POL_BIT 18
`define SOPD_SEL_HI 17
`define SOPD_SEL_LO 16
`define SOPD_PER_HI 15
`define SOPD_PER_LO 0

// byte lanes inside the 24-bit register
`define SOPD_B2_HI 23
`define SOPD_B2_LO 16
`define SOPD_B1_HI 15
`define SOPD_B1_LO 8
`define SOPD_B0_HI 7
`define SOPD_B0_LO 0

// field codes
`define SOPD_FP_KEY 4'hf
`define SOPD_SEL_D 2'b11
`define SOPD_TYPE_EDGE 1'b1

// smallest ratio the divider can realise from its own clock
`define SOPD_MIN_RATIO 24'h000002

`endif

// ===== sopd_pkg.sv
package sopd_pkg;

  // output waveform selected by the top nibble of the register
  typedef enum logic [1:0] {
    SOPD_CLOCK = 2'b01,
    SOPD_FRAME = 2'b10
  } sopd_mode_type;

endpackage

// ===== sopd_post_divider.sv
`timescale 1ns/100ps
`include "sopd_defines.svh"
module sopd_post_divider #(
  parameter int CFG_W = 24,
  parameter int PER_W = 16
) (
  input wire logic CLK, // divider input clock
  input wire logic SRST, // synchronous reset, active high
  input wire logic [7:0] REG_ADDR, // byte address
  input wire logic [7:0] REG_WDATA, // byte write data
  input wire logic REG_WR, // write strobe
  input wire logic SECOND_HIGH_PERF_OUTPUT_CLOCK, // related clock level
  output logic [7:0] REG_RDATA, // byte read data, one cycle late
  output sopd_pkg::sopd_mode_type MODE_STATE, // current waveform mode
  output logic CLK_OUT // divided clock or frame pulse
);
  import sopd_pkg::*;

  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] output_c_division_value;
  logic [CFG_W-1:0] eff_ratio;
  logic [CFG_W-1:0] div_cnt_r;
  logic [CFG_W-1:0] div_cnt_nxt;
  logic [PER_W-1:0] per_n;
  logic [PER_W-1:0] per_cnt_r;
  logic [PER_W-1:0] per_cnt_nxt;
  logic fp_mode;
  logic frame_active;
  logic pol;
  logic edge_type;
  logic rel_q_r;
  logic rel_rise;
  logic rel_fall;
  logic last_period;
  logic pulse_r;
  logic pulse_nxt;
  logic clk_out_nxt;
  logic [7:0] rdata_nxt;
  sopd_mode_type mode_r;

  // field decode
  assign fp_mode = (cfg_r[`SOPD_MODE_HI:`SOPD_MODE_LO] == `SOPD_FP_KEY);
  assign frame_active = fp_mode && (cfg_r[`SOPD_SEL_HI:`SOPD_SEL_LO] == `SOPD_SEL_D);
  assign pol = cfg_r[`SOPD_POL_BIT];
  assign edge_type = cfg_r[`SOPD_TYPE_BIT];
  assign per_n = cfg_r[`SOPD_PER_HI:`SOPD_PER_LO];
  assign output_c_division_value = cfg_r; // whole word is the ratio

  // configuration register, written a byte at a time
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cfg_r <= `SOPD_CFG_RESET;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `SOPD_ADDR_HI: cfg_r[`SOPD_B2_HI:`SOPD_B2_LO] <= REG_WDATA;
        `SOPD_ADDR_MID: cfg_r[`SOPD_B1_HI:`SOPD_B1_LO] <= REG_WDATA;
        `SOPD_ADDR_LO: cfg_r[`SOPD_B0_HI:`SOPD_B0_LO] <= REG_WDATA;
        default: cfg_r <= cfg_r; // other addresses belong to other blocks
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (REG_ADDR)
      `SOPD_ADDR_HI: rdata_nxt = cfg_r[`SOPD_B2_HI:`SOPD_B2_LO];
      `SOPD_ADDR_MID: rdata_nxt = cfg_r[`SOPD_B1_HI:`SOPD_B1_LO];
      `SOPD_ADDR_LO: rdata_nxt = cfg_r[`SOPD_B0_HI:`SOPD_B0_LO];
      default: rdata_nxt = 8'h00;
    endcase
  end

  // registered read data
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_nxt;
    end
  end

  // mode flag, kept in a flop so software can see it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mode_r <= SOPD_CLOCK;
    end else begin
      case (fp_mode)
        1'b1: mode_r <= SOPD_FRAME;
        default: mode_r <= SOPD_CLOCK;
      endcase
    end
  end
  assign MODE_STATE = mode_r;

  // ratios 0 and 1 cannot be made from this clock, so they run as 2
  assign eff_ratio = (output_c_division_value < `SOPD_MIN_RATIO) ? `SOPD_MIN_RATIO : output_c_division_value;

  // ratio counter; wraps on >= so a smaller new ratio takes effect at once
  always_comb begin
    if (fp_mode || (div_cnt_r >= eff_ratio - 24'h000001)) begin
      div_cnt_nxt = '0;
    end else begin
      div_cnt_nxt = div_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // related clock edges, sampled against the previous level
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rel_q_r <= 1'b0;
    end else begin
      rel_q_r <= SECOND_HIGH_PERF_OUTPUT_CLOCK;
    end
  end
  assign rel_rise = SECOND_HIGH_PERF_OUTPUT_CLOCK && !rel_q_r;
  assign rel_fall = !SECOND_HIGH_PERF_OUTPUT_CLOCK && rel_q_r;

  // a period count of zero never produces a pulse
  assign last_period = (per_n != '0) && (per_cnt_r >= per_n - 16'h0001);

  // related-period counter, frame boundary at its wrap
  always_comb begin
    if (!frame_active) begin
      per_cnt_nxt = '0;
    end else if (rel_rise) begin
      per_cnt_nxt = last_period ? '0 : per_cnt_r + 16'h0001;
    end else begin
      per_cnt_nxt = per_cnt_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      per_cnt_r <= '0;
    end else begin
      per_cnt_r <= per_cnt_nxt;
    end
  end

  // pulse spans one related period: edge type from boundary rise,
  // centred type from the fall before to the fall after
  always_comb begin
    pulse_nxt = pulse_r;
    if (!frame_active) begin
      pulse_nxt = 1'b0;
    end else if (edge_type == `SOPD_TYPE_EDGE) begin
      if (rel_rise) begin
        pulse_nxt = last_period;
      end
    end else if (rel_fall) begin
      pulse_nxt = last_period;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= pulse_nxt;
    end
  end

  // output select; a reserved selector parks the pulse at its idle level
  always_comb begin
    if (!fp_mode) begin
      clk_out_nxt = (div_cnt_nxt < (eff_ratio >> 1));
    end else if (frame_active) begin
      clk_out_nxt = pulse_nxt ^ pol;
    end else begin
      clk_out_nxt = pol;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      CLK_OUT <= 1'b0;
    end else begin
      CLK_OUT <= clk_out_nxt;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_boundary;
    frame_active && rel_rise && last_period;
  endsequence

  sequence s_mid_period;
    frame_active && rel_rise && !last_period;
  endsequence

  a_reset_default: assert property (@(posedge CLK) disable iff (1'b0) SRST |=> cfg_r == `SOPD_CFG_RESET)
    else $error("register not at default after reset");
  a_mode_follows: assert property ($changed(cfg_r[`SOPD_MODE_HI:`SOPD_MODE_LO]) |=> ##1
    (mode_r == SOPD_FRAME) == (cfg_r[`SOPD_MODE_HI:`SOPD_MODE_LO] == `SOPD_FP_KEY))
    else $error("mode flag does not follow top nibble");
  a_ratio_wrap: assert property (!fp_mode && div_cnt_r == eff_ratio - 24'h000001 && $stable(cfg_r)
    |=> div_cnt_r == 0)
    else $error("divider did not wrap at ratio");
  // output flop follows the counter, so counts 0 and 1 show high and 2 and 3 low
  a_even_duty: assert property (!fp_mode && cfg_r == 24'h000004 && div_cnt_r == 0 ##1 $stable(cfg_r) [*3]
    |-> !CLK_OUT && !$past(CLK_OUT) && $past(CLK_OUT, 2))
    else $error("divide by four not 50 percent");
  a_period_wrap: assert property (s_boundary |=> per_cnt_r == 0)
    else $error("period counter did not restart at boundary");
  a_edge_pulse: assert property (s_boundary ##0 edge_type |=> pulse_r)
    else $error("edge pulse missing at boundary");
  a_edge_width: assert property (s_mid_period ##0 edge_type |=> !pulse_r)
    else $error("edge pulse longer than one period");
  a_centre_pulse: assert property (frame_active && rel_fall && !edge_type |=> pulse_r == $past(last_period))
    else $error("centred pulse wrong at falling edge");
  // output and pulse flops load from the same next value, so they agree in the same cycle
  a_fp_polarity: assert property (frame_active && $stable(cfg_r) |-> CLK_OUT == (pulse_r ^ pol))
    else $error("frame pulse polarity wrong");
  a_reserved_idle: assert property (fp_mode && !frame_active |=> CLK_OUT == $past(pol))
    else $error("reserved selector did not park output");

endmodule // sopd_post_divider

// ===== synth_output_post_divider_fp_bench.sv
`timescale 1ns/100ps
`include "sopd_defines.svh"
module synth_output_post_divider_fp_bench;
  import sopd_pkg::*;
  logic CLK, SRST, REG_WR, SECOND_HIGH_PERF_OUTPUT_CLOCK, CLK_OUT, rel_at;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
  sopd_mode_type MODE_STATE;
  int error_cnt = 0;
  int samples_checked = 0;
  int w, p, bad;
  int rat[5] = '{4, 5, 6, 7, 257};
  logic [7:0] fhi[4] = '{8'hfb, 8'hff, 8'hf3, 8'hf7};
  int fn[4] = '{3, 5, 3, 4};

  sopd_post_divider i_dut (
    .CLK(CLK), // divider clock
    .SRST(SRST), // sync reset
    .REG_ADDR(REG_ADDR), // byte address
    .REG_WDATA(REG_WDATA), // write byte
    .REG_WR(REG_WR), // write strobe
    .SECOND_HIGH_PERF_OUTPUT_CLOCK(SECOND_HIGH_PERF_OUTPUT_CLOCK), // related clock
    .REG_RDATA(REG_RDATA), // read byte
    .MODE_STATE(MODE_STATE), // waveform mode
    .CLK_OUT(CLK_OUT) // output
  );

  // 25 mhz divider clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // related clock of eight divider cycles, free running so mode changes see it at once
  initial begin
    SECOND_HIGH_PERF_OUTPUT_CLOCK = 1'b0;
    forever begin
      repeat (4) @(posedge CLK);
      #1 SECOND_HIGH_PERF_OUTPUT_CLOCK = ~SECOND_HIGH_PERF_OUTPUT_CLOCK;
    end
  end

  task automatic results;
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (90000) @(posedge CLK);
    error_cnt++;
    $display("CHECK FAILED run length expected end seen timeout");
    results();
  end

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // a bounded wait that ran out counts as a mismatch and ends the run
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      $display("CHECK FAILED output edge expected within %0d seen none", lim);
      results();
    end
  endtask

  task automatic tick;
    @(posedge CLK);
    #1;
  endtask

  // three bytes back to back, strobe held high throughout
  task automatic cfg(input logic [23:0] v);
    REG_WR = 1'b1;
    REG_ADDR = `SOPD_ADDR_HI;
    REG_WDATA = v[23:16];
    tick();
    REG_ADDR = `SOPD_ADDR_MID;
    REG_WDATA = v[15:8];
    tick();
    REG_ADDR = `SOPD_ADDR_LO;
    REG_WDATA = v[7:0];
    tick();
    REG_WR = 1'b0;
    tick();
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    REG_ADDR = a;
    tick();
    chk("read data", {16'h0000, exp}, {16'h0000, REG_RDATA});
  endtask

  // active run length and start-to-start period; second pass avoids a stale first cycle
  task automatic measure(input logic act);
    repeat (2) begin
      w = 0;
      while (CLK_OUT === act && w < 800) begin tick(); w++; end
      limit(w, 800);
      w = 0;
      while (CLK_OUT !== act && w < 800) begin tick(); w++; end
      limit(w, 800);
      rel_at = SECOND_HIGH_PERF_OUTPUT_CLOCK;
      w = 0;
      while (CLK_OUT === act && w < 800) begin tick(); w++; end
      limit(w, 800);
      p = w;
      while (CLK_OUT !== act && p < 1600) begin tick(); p++; end
      limit(p, 1600);
    end
  endtask

  initial begin
    SRST = 1'b1;
    REG_WR = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    repeat (2) @(posedge CLK);
    #1 SRST = 1'b0;
    rd(8'h86, 8'h00);
    rd(8'h87, 8'h00);
    rd(8'h88, 8'h40);
    rd(8'h89, 8'h00);
    chk("mode", {22'h0, SOPD_CLOCK}, {22'h0, MODE_STATE});
    measure(1'b1);
    chk("high", 32, w);
    chk("period", 64, p);
    $display("test reset done");
    foreach (rat[i]) begin
      cfg(rat[i]); // ratios kept far below the maximum
      rd(8'h87, rat[i] >> 8);
      measure(1'b1);
      chk("high", rat[i] / 2, w);
      chk("period", rat[i], p);
    end
    $display("test clock ratios done");
    // bit 19 type, bit 18 polarity, selector 11
    foreach (fhi[i]) begin
      cfg({fhi[i], fn[i][15:0]}); // related clock is always another divider
      chk("mode", {22'h0, SOPD_FRAME}, {22'h0, MODE_STATE});
      measure(~fhi[i][2]);
      chk("width", 8, w);
      chk("period", 8 * fn[i], p);
      chk("boundary", fhi[i][3], rel_at);
    end
    $display("test frame pulse done");
    // reserved selectors park at the idle level
    for (int s = 0; s < 3; s++) begin
      cfg({4'hf, 1'b1, s[0], s[1:0], 16'h0002});
      bad = 0;
      repeat (60) begin tick(); if (CLK_OUT !== s[0]) bad++; end
      chk("idle", 0, bad);
    end
    $display("test reserved select done");
    // reset in mid-run drops frame mode and restores the default ratio
    SRST = 1'b1;
    tick();
    tick();
    SRST = 1'b0;
    rd(8'h86, 8'h00);
    rd(8'h88, 8'h40);
    chk("mode", {22'h0, SOPD_CLOCK}, {22'h0, MODE_STATE});
    $display("test mid-run reset done");
    cfg(24'h000008);
    chk("mode", {22'h0, SOPD_CLOCK}, {22'h0, MODE_STATE});
    measure(1'b1);
    chk("period", 8, p);
    $display("test return to clock done");
    results();
  end
endmodule // synth_output_post_divider_fp_bench
